// ==== src/cocg_pkg.sv ====
package cocg_pkg;
   localparam int NUM_BANKS = 10;
   localparam int NUM_DIV = 5;
   localparam int DIV_W = 5;
   localparam int NUM_PROFILES = 4;
   localparam int PS_W = 2;
   localparam int SEL_W = 3;
   localparam int STD_W = 3;
   localparam int LOCK_W = 4;
   // Matched reference periods before lock is reported
   localparam logic [LOCK_W-1:0] LOCK_COUNT = 4'h8;
   localparam logic [DIV_W-1:0] DIV_RESET = 5'h00;

   typedef enum logic [1:0] {OE_ALWAYS, OE_OFF, OE_FIRST, OE_SECOND} cocg_oe_mode_t;

   typedef struct packed {
      logic [SEL_W-1:0] divider;
      logic [STD_W-1:0] driver_std;
      logic gate_en;
      cocg_oe_mode_t oe_a;
      cocg_oe_mode_t oe_b;
   } cocg_bank_cfg_t;

   typedef struct packed {
      cocg_bank_cfg_t [NUM_BANKS-1:0] bank;
      logic [NUM_DIV-1:0][DIV_W-1:0] post_div;
      logic [DIV_W-1:0] pre_div;
   } cocg_profile_t;

   localparam cocg_profile_t PROFILE_RESET = '0;

   typedef struct packed {
      logic reference_input_select;
      logic feedback_input_select;
      logic sync_output_gate;
      logic output_enable_first;
      logic output_enable_second;
      logic global_output_enable;
      logic loop_bypass;
      logic profile_select_bit1;
      logic profile_select_bit0;
   } cocg_ctl_t;

   typedef struct packed {
      logic reference_pair_first;
      logic reference_pair_second;
      logic feedback_pair_first;
      logic feedback_pair_second;
      logic oscillator;
   } cocg_clk_in_t;
endpackage

// ==== src/cocg_prof_mem.sv ====
`timescale 1ns/1ps
module cocg_prof_mem
#(
   parameter int DEPTH = 4,
   parameter int AW = 2,
   parameter int W = 8
)
(
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire logic i_wr,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [W-1:0] i_wdata,
   input wire logic [AW-1:0] i_raddr,
   output logic [W-1:0] o_rdata
);
   logic [W-1:0] mem [DEPTH];

   // Profile store
   always_ff @(posedge i_mclk)
   begin
      if (i_ce && i_wr)
         mem[i_waddr] <= i_wdata;
   end

   // Registered read
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
         o_rdata <= '0;
      else if (i_ce)
         o_rdata <= mem[i_raddr];
   end
endmodule

// ==== src/cocg_clock_output_control.sv ====
`timescale 1ns/1ps
// Summary of operation
// RULE1: Reference select low routes the first reference pair to the loop, high the second.
// RULE2: Feedback select low uses the first feedback pair as loop feedback, high the second.
// RULE3: A bank with gating enabled passes its clock while the gate is high and holds low while it is low.
// RULE4: Gate changes never produce a truncated or partial output pulse.
// RULE5: Each output is always driven, always off, or driven by the first or second enable input.
// RULE6: A high global output enable puts every output in high impedance, over all other settings.
// RULE7: A high global output enable also cuts the feedback path so the loop loses lock.
// RULE8: The two profile select inputs pick one of four stored configuration profiles.
// RULE9: With bypass low the post-loop dividers run from the internal oscillator.
// RULE10: With bypass high the post-loop dividers run from the reference prescaler output.
// RULE11: Reset high clears all counters and removes the lock indication.
// RULE12: The lock output is low while locked and high otherwise.
// RULE13: Each bank picks one of five post-loop dividers and its driver standard.
// RULE14: The gate is sampled in the output clock's timing and acts only at a whole-period boundary.
module cocg_clock_output_control
   import cocg_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_ce,
   input wire cocg_pkg::cocg_ctl_t i_ctl,
   input wire cocg_pkg::cocg_clk_in_t i_clk_in,
   input wire logic i_cfg_wr,
   input wire logic [cocg_pkg::PS_W-1:0] i_cfg_addr,
   input wire cocg_pkg::cocg_profile_t i_cfg_data,
   output logic o_lock_n,
   output logic [2*cocg_pkg::NUM_BANKS-1:0] o_out_clk,
   output logic [2*cocg_pkg::NUM_BANKS-1:0] o_out_oe,
   output logic [cocg_pkg::NUM_BANKS-1:0][cocg_pkg::STD_W-1:0] o_bank_std
);
   import cocg_pkg::*;

   localparam int SYNC_W = $bits(cocg_ctl_t) + $bits(cocg_clk_in_t);

   function automatic logic [DIV_W:0] div_step(input logic [DIV_W-1:0] cnt, input logic [DIV_W-1:0] ratio);
      if (cnt >= ratio)
         return {1'b1, DIV_RESET};
      return {1'b0, DIV_W'(cnt + 1'b1)};
   endfunction

   function automatic logic oe_decode(input cocg_oe_mode_t mode, input cocg_ctl_t c);
      return !c.global_output_enable && ((mode == OE_ALWAYS) || (mode == OE_FIRST && c.output_enable_first)
         || (mode == OE_SECOND && c.output_enable_second));
   endfunction

   // Two-stage pin synchroniser
   logic [SYNC_W-1:0] sync1;
   logic [SYNC_W-1:0] sync2;
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else if (i_ce)
      begin
         sync1 <= {i_ctl, i_clk_in};
         sync2 <= sync1;
      end
   end

   cocg_ctl_t ctl;
   cocg_clk_in_t cin;
   assign {ctl, cin} = sync2;

   // Profile selection
   cocg_profile_t cfg;
   wire [PS_W-1:0] prof_sel = {ctl.profile_select_bit1, ctl.profile_select_bit0}; // [RULE8]
   cocg_prof_mem #(.DEPTH(NUM_PROFILES), .AW(PS_W), .W($bits(cocg_profile_t))) u_prof_mem
   (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_ce(i_ce),
      .i_wr(i_cfg_wr),
      .i_waddr(i_cfg_addr),
      .i_wdata(i_cfg_data),
      .i_raddr(prof_sel),
      .o_rdata(cfg)
   );

   // Input selection
   wire ref_sel = ctl.reference_input_select ? cin.reference_pair_second : cin.reference_pair_first; // [RULE1]
   wire fbk_sel = ctl.feedback_input_select ? cin.feedback_pair_second : cin.feedback_pair_first; // [RULE2]
   wire fbk_buf = fbk_sel && !ctl.global_output_enable; // [RULE7]

   logic ref_q;
   logic fbk_q;
   logic pre_clk;
   logic [DIV_W-1:0] pre_cnt;
   logic pre_q;
   logic src_q;
   logic [NUM_DIV-1:0] post_clk;
   logic [NUM_DIV-1:0][DIV_W-1:0] post_cnt;
   logic fb_seen;
   logic [LOCK_W-1:0] match_cnt;

   wire ref_edge = ref_sel && !ref_q;
   wire fbk_edge = fbk_buf && !fbk_q;
   wire [DIV_W:0] pre_next = div_step(pre_cnt, cfg.pre_div);
   wire src = ctl.loop_bypass ? pre_clk : cin.oscillator; // [RULE9] [RULE10]
   wire src_edge = src && !src_q;
   wire pre_edge = pre_clk && !pre_q;
   wire locked = (match_cnt == LOCK_COUNT);

   // Prescaler and edge history
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         ref_q <= 1'b0;
         fbk_q <= 1'b0;
         src_q <= 1'b0;
         pre_q <= 1'b0;
         pre_clk <= 1'b0;
         pre_cnt <= DIV_RESET; // [RULE11]
      end
      else if (i_ce)
      begin
         ref_q <= ref_sel;
         fbk_q <= fbk_buf;
         src_q <= src;
         pre_q <= pre_clk;
         if (ref_edge)
         begin
            pre_cnt <= pre_next[DIV_W-1:0];
            pre_clk <= pre_clk ^ pre_next[DIV_W];
         end
      end
   end

   // Post-loop dividers
   for (genvar d = 0; d < NUM_DIV; d++)
   begin : g_div
      wire [DIV_W:0] nxt = div_step(post_cnt[d], cfg.post_div[d]);
      always_ff @(posedge i_mclk)
      begin
         if (i_reset)
         begin
            post_cnt[d] <= DIV_RESET; // [RULE11]
            post_clk[d] <= 1'b0;
         end
         else if (i_ce && src_edge)
         begin
            post_cnt[d] <= nxt[DIV_W-1:0];
            post_clk[d] <= post_clk[d] ^ nxt[DIV_W];
         end
      end
   end

   // Lock detection: at least one feedback edge per prescaled reference period
   always_ff @(posedge i_mclk)
   begin
      if (i_reset)
      begin
         fb_seen <= 1'b0;
         match_cnt <= '0; // [RULE11]
         o_lock_n <= 1'b1;
      end
      else if (i_ce)
      begin
         if (pre_edge)
         begin
            fb_seen <= fbk_edge;
            if (!fb_seen)
               match_cnt <= '0; // [RULE7]
            else if (!locked)
               match_cnt <= LOCK_W'(match_cnt + 1'b1);
         end
         else if (fbk_edge)
            fb_seen <= 1'b1;
         o_lock_n <= !locked; // [RULE12]
      end
   end

   // Banks
   logic [NUM_BANKS-1:0] bank_clk;
   logic [NUM_BANKS-1:0] bank_q;
   logic [NUM_BANKS-1:0] gate_on;
   for (genvar b = 0; b < NUM_BANKS; b++)
   begin : g_bank
      wire [SEL_W-1:0] dsel = cfg.bank[b].divider;
      assign bank_clk[b] = (dsel < SEL_W'(NUM_DIV)) ? post_clk[dsel] : post_clk[0]; // [RULE13]
      wire period_end = bank_q[b] && !bank_clk[b];
      wire gated = cfg.bank[b].gate_en ? (bank_clk[b] && gate_on[b]) : bank_clk[b]; // [RULE3]
      always_ff @(posedge i_mclk)
      begin
         if (i_reset)
         begin
            bank_q[b] <= 1'b0;
            gate_on[b] <= 1'b0;
            o_out_clk[2*b+1 -: 2] <= 2'h0;
            o_out_oe[2*b+1 -: 2] <= 2'h0;
            o_bank_std[b] <= '0;
         end
         else if (i_ce)
         begin
            bank_q[b] <= bank_clk[b];
            if (period_end)
               gate_on[b] <= ctl.sync_output_gate; // [RULE4] [RULE14]
            o_out_clk[2*b+1 -: 2] <= {2{gated}};
            o_out_oe[2*b] <= oe_decode(cfg.bank[b].oe_a, ctl); // [RULE5] [RULE6]
            o_out_oe[2*b+1] <= oe_decode(cfg.bank[b].oe_b, ctl);
            o_bank_std[b] <= cfg.bank[b].driver_std; // [RULE13]
         end
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   sequence s_gate_drop(int bi);
      gate_on[bi] ##1 !gate_on[bi];
   endsequence

   ref_mux_a: assert property (i_ce |=> ref_q == // [RULE1]
      ($past(ctl.reference_input_select) ? $past(cin.reference_pair_second) : $past(cin.reference_pair_first)))
      else $error("reference select mismatch");
   fbk_mux_a: assert property (i_ce && !ctl.global_output_enable |=> fbk_q == // [RULE2]
      ($past(ctl.feedback_input_select) ? $past(cin.feedback_pair_second) : $past(cin.feedback_pair_first)))
      else $error("feedback select mismatch");
   gate_hold_a: assert property (i_ce && cfg.bank[0].gate_en && !gate_on[0] |=> !i_ce || !o_out_clk[0]) // [RULE3]
      else $error("gated bank not held");
   gate_edge_a: assert property (s_gate_drop(0) |-> !bank_clk[0]) // [RULE4]
      else $error("gate changed inside a pulse");
   gate_bound_a: assert property ($changed(gate_on[1]) |-> $past(bank_q[1]) && !$past(bank_clk[1])) // [RULE14]
      else $error("gate changed off a period boundary");
   goe_hiz_a: assert property (i_ce && ctl.global_output_enable |=> !i_ce || o_out_oe == '0) // [RULE6]
      else $error("output driven under global disable");
   goe_fbk_a: assert property (i_ce && ctl.global_output_enable |=> !i_ce || !fbk_q) // [RULE7]
      else $error("feedback alive under global disable");
   reset_lock_a: assert property (disable iff (1'b0) i_reset |=> o_lock_n && match_cnt == '0) // [RULE11]
      else $error("reset left lock or counters");
   lock_pin_a: assert property (i_ce && locked |=> !i_ce || !o_lock_n) // [RULE12]
      else $error("lock not shown low");
   bypass_src_a: assert property (i_ce && ctl.loop_bypass && !(pre_clk && !src_q) |=> $stable(post_clk)) // [RULE10]
      else $error("dividers moved without a prescaler edge");
endmodule

// ==== testbench/cocg_board_model.sv ====
`timescale 1ns/1ps
module cocg_board_model
   import cocg_pkg::*;
#(
   parameter int HALF = 4
)
(
   input wire logic i_mclk,
   input wire logic [4:0] i_run,
   output cocg_pkg::cocg_clk_in_t o_clk
);
   int cnt = 0;
   logic [4:0] lvl = 5'h00;
   // Running sources toggle every HALF cycles, stopped ones stand still
   always @(posedge i_mclk)
   begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
         lvl <= lvl ^ i_run;
   end
   assign o_clk = lvl;
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import cocg_pkg::*;
   localparam int HALF = 4;
   localparam logic [4:0] RA = 5'h10, RB = 5'h08, FA = 5'h04, FB = 5'h02, OS = 5'h01;
   logic i_mclk, i_reset, i_ce, i_cfg_wr;
   logic [PS_W-1:0] i_cfg_addr;
   cocg_ctl_t i_ctl;
   cocg_profile_t i_cfg_data;
   cocg_clk_in_t clk_in;
   logic [4:0] run;
   logic o_lock_n;
   logic [2*NUM_BANKS-1:0] o_out_clk, o_out_oe, eoe;
   logic [NUM_BANKS-1:0][STD_W-1:0] o_bank_std;
   logic [STD_W-1:0] std [NUM_PROFILES];
   int errors, checked, seed, t, len;
   cocg_board_model #(.HALF(HALF)) cocg_board_model_i (.i_mclk(i_mclk), .i_run(run), .o_clk(clk_in));
   cocg_clock_output_control cocg_clock_output_control_i (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce),
      .i_ctl(i_ctl), .i_clk_in(clk_in), .i_cfg_wr(i_cfg_wr), .i_cfg_addr(i_cfg_addr), .i_cfg_data(i_cfg_data),
      .o_lock_n(o_lock_n), .o_out_clk(o_out_clk), .o_out_oe(o_out_oe), .o_bank_std(o_bank_std));
   initial
   begin
      i_mclk = 1'b0;
      forever #25 i_mclk = ~i_mclk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
      #2;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      checked++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic toggles(output int n);
      logic last;
      n = 0;
      tick(20);
      last = o_out_clk[0];
      repeat (300)
      begin
         tick(1);
         if (o_out_clk[0] !== last)
            n++;
         last = o_out_clk[0];
      end
   endtask
   function automatic cocg_profile_t mkp(input int k, input logic g);
      cocg_profile_t p;
      p = PROFILE_RESET;
      for (int b = 0; b < NUM_BANKS; b++)
      begin
         p.bank[b].driver_std = std[k];
         p.bank[b].divider = SEL_W'(k);
         p.bank[b].gate_en = g;
         p.bank[b].oe_a = cocg_oe_mode_t'(k);
         p.bank[b].oe_b = cocg_oe_mode_t'((k + 1) % 4);
      end
      for (int d = 0; d < NUM_DIV; d++)
         p.post_div[d] = DIV_W'(d);
      return p;
   endfunction
   function automatic int pulse(input int div);
      return 2 * HALF * (div + 1);
   endfunction
   function automatic logic oe_on(input int m, input logic f, input logic s, input logic g);
      return !g && (m == OE_ALWAYS || (m == OE_FIRST && f) || (m == OE_SECOND && s));
   endfunction
   task automatic results;
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      #2000000;
      errors++;
      results();
   end
   initial
   begin
      errors = 0;
      checked = 0;
      seed = 53;
      i_reset = 1'b1;
      i_ce = 1'b1;
      i_cfg_wr = 1'b0;
      i_cfg_addr = '0;
      i_cfg_data = '0;
      i_ctl = '0;
      run = '0;
      tick(12);
      chk(o_lock_n, 1'b1, "lock in reset");
      chk(o_out_clk, '0, "clk in reset");
      i_reset = 1'b0;
      for (int k = 0; k < NUM_PROFILES; k++)
      begin
         std[k] = STD_W'($random(seed));
         i_cfg_wr = 1'b1;
         i_cfg_addr = k[1:0];
         i_cfg_data = mkp(k, 1'b0);
         tick(1);
      end
      i_cfg_wr = 1'b0;
      for (int k = 0; k < NUM_PROFILES; k++)
         for (int c = 0; c < 8; c++)
         begin
            {i_ctl.profile_select_bit1, i_ctl.profile_select_bit0} = k[1:0];
            {i_ctl.global_output_enable, i_ctl.output_enable_second, i_ctl.output_enable_first} = c[2:0];
            tick(6);
            for (int b = 0; b < NUM_BANKS; b++)
            begin
               eoe[2*b] = oe_on(k, c[0], c[1], c[2]);
               eoe[2*b+1] = oe_on((k + 1) % 4, c[0], c[1], c[2]);
            end
            chk(o_bank_std, {NUM_BANKS{std[k]}}, "standard");
            chk(o_out_oe, eoe, "enables");
         end
      i_ctl = '0;
      run = RA | FA;
      tick(400);
      chk(o_lock_n, 1'b0, "lock a");
      i_ctl.feedback_input_select = 1'b1;
      tick(200);
      chk(o_lock_n, 1'b1, "fb b idle");
      run = RA | FB;
      tick(400);
      chk(o_lock_n, 1'b0, "lock b");
      i_ctl.global_output_enable = 1'b1;
      tick(200);
      chk(o_lock_n, 1'b1, "global off");
      i_ctl.global_output_enable = 1'b0;
      tick(400);
      chk(o_lock_n, 1'b0, "relock");
      i_reset = 1'b1;
      tick(3);
      chk(o_lock_n, 1'b1, "mid reset");
      chk(o_out_clk, '0, "mid reset clk");
      i_reset = 1'b0;
      i_ctl = '0;
      i_ctl.loop_bypass = 1'b1;
      run = RA;
      toggles(t);
      chk(t > 0, 1'b1, "bypass ref a");
      i_ctl.reference_input_select = 1'b1;
      toggles(t);
      chk(t == 0, 1'b1, "ref b idle");
      run = RB;
      toggles(t);
      chk(t > 0, 1'b1, "bypass ref b");
      i_ctl.loop_bypass = 1'b0;
      toggles(t);
      chk(t == 0, 1'b1, "osc idle");
      run = OS;
      toggles(t);
      chk(t > 0, 1'b1, "osc run");
      i_cfg_wr = 1'b1;
      i_cfg_addr = 2'h3;
      i_cfg_data = mkp(3, 1'b1);
      tick(1);
      i_cfg_wr = 1'b0;
      {i_ctl.profile_select_bit1, i_ctl.profile_select_bit0} = 2'h3;
      toggles(t);
      chk(t == 0, 1'b1, "gated");
      chk(o_out_clk, '0, "gated low");
      i_ctl.sync_output_gate = 1'b1;
      toggles(t);
      chk(t > 0, 1'b1, "gate open");
      while (o_out_clk[0] === 1'b1)
         tick(1);
      len = 0;
      repeat (2000)
      begin
         if ($random(seed) % 40 == 0)
            i_ctl.sync_output_gate = ~i_ctl.sync_output_gate;
         tick(1);
         if (o_out_clk[0] === 1'b1)
            len++;
         else
         begin
            if (len != 0)
               chk(len, pulse(3), "pulse width");
            len = 0;
         end
      end
      results();
   end
endmodule
